//--- design/ifd_decode.sv
`timescale 1ns/1ps

module ifd_decode
  import ifd_pkg::*;
(
  input wire logic clock,             // oscillator clock
  input wire logic rst,               // async reset, active high
  input wire logic [15:0] instr_word, // word from program memory
  input wire logic cond_true,         // execute unit: test of current instr true
  output logic [1:0] phase_ff,        // oscillator quarter
  output logic fetch_ff,              // pulse: fetch next word
  output logic issue_ff,              // pulse: dec_ff holds a new decode
  output ifd_dec_type dec_ff,         // decoded instruction
  output logic wr_accum_ff            // result goes to working_accumulator
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_first_of_two(input logic [15:0] w);
    logic r;
    r = 1'b0;
    casez (w[OPC_MSB:OPC_LSB])
      8'b1100_????: r = 1'b1; // file to file move
      8'b1110_1110: r = 1'b1; // pointer load
      8'b1110_1111: r = 1'b1; // absolute jump
      8'b1110_110?: r = 1'b1; // call
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_first_of_two

  function automatic ifd_dec_type dec_first(input logic [15:0] w);
    ifd_dec_type d;
    d = '0;
    d.opcode = w[OPC_MSB:OPC_LSB];
    d.cycles = CYC_ONE;
    d.file_addr = {4'h0, w[FILE_MSB:FILE_LSB]};
    d.dest_file = w[DEST_BIT];
    d.use_bank = w[ACC_BIT];
    d.bit_num = w[BITN_MSB:BITN_LSB];
    d.literal = {12'h000, w[LIT_MSB:LIT_LSB]};
    d.cls = CLS_BYTE;
    priority casez (w[OPC_MSB:OPC_LSB])
      8'b0000_0000:
      begin
        // control with mode or no operand
        d.cls = (w == WORD_NOP) ? CLS_NOP : CLS_CTRL;
        d.tbl_mode = w[TBL_MSB:TBL_LSB];
        d.fast = (w[7:1] == 7'h08) || (w[7:1] == 7'h09) ? w[FAST_RET_BIT] : 1'b0;
        d.pc_change = (w[7:1] == 7'h08) || (w[7:1] == 7'h09);
      end
      8'b0000_0001, 8'b0000_1???:
      begin
        d.cls = CLS_LIT;
      end
      8'b1111_????:
      begin
        d.cls = CLS_NOP;
      end
      8'b1100_????:
      begin
        d.two_word = 1'b1;
        d.file_addr = w[WIDE_MSB:WIDE_LSB];
      end
      8'b1110_1110:
      begin
        d.cls = CLS_LIT;
        d.two_word = 1'b1;
        d.ptr_sel = w[PTR_MSB:PTR_LSB];
        d.literal = {8'h00, w[LITHI_MSB:LITHI_LSB], 8'h00};
      end
      8'b1110_1111:
      begin
        d.cls = CLS_CTRL;
        d.two_word = 1'b1;
        d.pc_change = 1'b1;
        d.prog_addr = {12'h000, w[7:0]};
      end
      8'b1110_110?:
      begin
        // fast call saves into shadow registers
        d.cls = CLS_CTRL;
        d.two_word = 1'b1;
        d.pc_change = 1'b1;
        d.fast = w[FAST_CALL_BIT];
        d.prog_addr = {12'h000, w[7:0]};
      end
      8'b1110_0???:
      begin
        d.cls = CLS_CTRL;
        d.cond = 1'b1;
        d.prog_addr = {{12{w[SBR_MSB]}}, w[SBR_MSB:0]};
      end
      8'b1101_????:
      begin
        d.cls = CLS_CTRL;
        d.pc_change = 1'b1;
        d.prog_addr = {{9{w[BRA_MSB]}}, w[BRA_MSB:0]};
      end
      8'b0111_????, 8'b100?_????:
      begin
        d.cls = CLS_BIT;
      end
      8'b101?_????:
      begin
        // bit test and skip
        d.cls = CLS_BIT;
        d.cond = 1'b1;
      end
      8'b0010_11??, 8'b0011_11??, 8'b0100_1???, 8'b0110_0???:
      begin
        // byte test and skip
        d.cond = 1'b1;
      end
      default:
      begin
        d.cls = CLS_BYTE;
      end
    endcase
    if (d.two_word)
    begin
      d.cycles = CYC_TWO;
    end
    return d;
  endfunction : dec_first

  function automatic ifd_dec_type dec_second(input ifd_dec_type f, input logic [15:0] w);
    ifd_dec_type d;
    d = f;
    d.dst_addr = w[WIDE_MSB:WIDE_LSB];
    if (f.cls == CLS_LIT)
    begin
      d.literal[7:0] = w[LIT_MSB:LIT_LSB];
    end
    if (f.cls == CLS_CTRL)
    begin
      d.prog_addr[19:8] = w[WIDE_MSB:WIDE_LSB];
    end
    return d;
  endfunction : dec_second

  // ****************************************
  // quarter sequencing
  // ****************************************
  logic cycle_end;
  logic discard_now;
  logic pend_pc_ff;
  logic pend_cond_ff;
  ifd_state_type st_ff;
  ifd_state_type nxt_st;
  ifd_dec_type nxt_dec;
  ifd_dec_type nop_dec;

  ifd_quarter_seq u_quarter (
    .clock(clock),
    .rst(rst),
    .phase_ff(phase_ff)
  );

  assign cycle_end = (phase_ff == QTR_LAST);

  // extra cycle when a single-word instr changed pc or test true
  assign discard_now = pend_pc_ff || (pend_cond_ff && cond_true);

  // ****************************************
  // next decode
  // ****************************************
  always_comb
  begin
    nop_dec = '0;
    nop_dec.cls = CLS_NOP;
    nop_dec.cycles = CYC_ONE;
    nop_dec.discard = 1'b1;
    nxt_st = st_ff;
    nxt_dec = dec_ff;
    unique case (st_ff)
      ST_SINGLE:
      begin
        if (discard_now)
        begin
          nxt_dec = nop_dec;
        end
        else
        begin
          nxt_dec = dec_first(instr_word);
          if (is_first_of_two(instr_word))
          begin
            nxt_st = ST_SECOND;
          end
        end
      end
      ST_SECOND:
      begin
        nxt_dec = dec_second(dec_ff, instr_word);
        nxt_st = ST_SINGLE;
      end
    endcase
  end

  // state and decode register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= ST_SINGLE;
      dec_ff <= '0;
      wr_accum_ff <= 1'b0;
    end
    else if (cycle_end)
    begin
      st_ff <= nxt_st;
      dec_ff <= nxt_dec;
      wr_accum_ff <= (nxt_dec.cls == CLS_BYTE) && !nxt_dec.dest_file && !nxt_dec.two_word;
    end
  end

  // flush bookkeeping for the next cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pend_pc_ff <= 1'b0;
      pend_cond_ff <= 1'b0;
    end
    else if (cycle_end)
    begin
      pend_pc_ff <= (st_ff == ST_SINGLE) && !discard_now && nxt_dec.pc_change
        && !nxt_dec.two_word;
      pend_cond_ff <= (st_ff == ST_SINGLE) && !discard_now && nxt_dec.cond;
    end
  end

  // fetch and issue strobes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fetch_ff <= 1'b0;
      issue_ff <= 1'b0;
    end
    else
    begin
      fetch_ff <= cycle_end;
      issue_ff <= cycle_end;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_quarter_wrap: assert property (@(posedge clock) disable iff (rst)
    issue_ff |-> ##1 !issue_ff [*3] ##1 issue_ff)
    else $error("issue spacing is not four clocks");
  a_second_word_nop: assert property (@(posedge clock) disable iff (rst)
    (cycle_end && st_ff == ST_SINGLE && !discard_now && instr_word[TAG_MSB:TAG_LSB] == SECOND_TAG)
    |=> dec_ff.cls == CLS_NOP)
    else $error("lone second word did not decode as no_operation");
  a_two_word_len: assert property (@(posedge clock) disable iff (rst)
    (cycle_end && st_ff == ST_SINGLE && !discard_now && is_first_of_two(instr_word))
    |=> st_ff == ST_SECOND ##4 (st_ff == ST_SINGLE && dec_ff.cycles == CYC_TWO))
    else $error("two-word instruction did not span two cycles");
  a_dest_select: assert property (@(posedge clock) disable iff (rst)
    (issue_ff && dec_ff.cls == CLS_BYTE && !dec_ff.two_word)
    |-> wr_accum_ff == !$past(instr_word[DEST_BIT]))
    else $error("destination select not honoured");
  a_bank_select: assert property (@(posedge clock) disable iff (rst)
    (issue_ff && dec_ff.cls inside {CLS_BYTE, CLS_BIT} && !dec_ff.two_word)
    |-> dec_ff.use_bank == $past(instr_word[ACC_BIT]))
    else $error("memory select not honoured");
  a_bit_number: assert property (@(posedge clock) disable iff (rst)
    (issue_ff && dec_ff.cls == CLS_BIT)
    |-> dec_ff.bit_num == $past(instr_word[BITN_MSB:BITN_LSB])
      && dec_ff.file_addr[7:0] == $past(instr_word[FILE_MSB:FILE_LSB]))
    else $error("bit operand fields wrong");
  a_byte_fields: assert property (@(posedge clock) disable iff (rst)
    (issue_ff && dec_ff.cls == CLS_BYTE && !dec_ff.two_word)
    |-> dec_ff.file_addr[7:0] == $past(instr_word[FILE_MSB:FILE_LSB])
      && dec_ff.opcode == $past(instr_word[OPC_MSB:OPC_LSB]))
    else $error("byte operand fields wrong");
  a_literal_field: assert property (@(posedge clock) disable iff (rst)
    (issue_ff && dec_ff.cls == CLS_LIT && !dec_ff.two_word)
    |-> dec_ff.literal[7:0] == $past(instr_word[LIT_MSB:LIT_LSB]))
    else $error("literal operand wrong");
  a_flush_cycle: assert property (@(posedge clock) disable iff (rst)
    (issue_ff && dec_ff.pc_change && !dec_ff.two_word && !dec_ff.discard)
    |-> ##4 (dec_ff.cls == CLS_NOP && dec_ff.discard))
    else $error("word after pc change was not discarded");

  a_cond_flush: assert property (@(posedge clock) disable iff (rst)
    (cycle_end && pend_cond_ff && !pend_pc_ff && !cond_true && st_ff == ST_SINGLE)
    |=> !dec_ff.discard)
    else $error("false test added a cycle");

  a_fast_ctrl: assert property (@(posedge clock) disable iff (rst)
    (issue_ff && dec_ff.fast) |-> dec_ff.cls == CLS_CTRL)
    else $error("fast mode outside call or return");

  a_call_addr: assert property (@(posedge clock) disable iff (rst)
    (cycle_end && st_ff == ST_SECOND && dec_ff.cls == CLS_CTRL)
    |=> dec_ff.prog_addr[19:8] == $past(instr_word[WIDE_MSB:WIDE_LSB]))
    else $error("second word address not joined");

endmodule : ifd_decode

//--- design/ifd_pkg.sv
package ifd_pkg;

  // ****************************************
  // instruction cycle timing
  // ****************************************
  localparam int unsigned OSC_PER_CYCLE = 4;          // oscillator periods per cycle
  localparam logic [1:0] QTR_RESET = 2'h0;            // quarter after reset
  localparam logic [1:0] QTR_LAST = 2'(OSC_PER_CYCLE - 1); // quarter that closes a cycle
  localparam logic [1:0] CYC_ONE = 2'h1;              // plain single-word length
  localparam logic [1:0] CYC_TWO = 2'h2;              // two-word instruction length

  // ****************************************
  // field positions inside a program word
  // ****************************************
  localparam int TAG_MSB = 15;      // top nibble of a word
  localparam int TAG_LSB = 12;
  localparam int OPC_MSB = 15;      // opcode byte
  localparam int OPC_LSB = 8;
  localparam int DEST_BIT = 9;      // destination select
  localparam int ACC_BIT = 8;       // accessed-memory select
  localparam int FILE_MSB = 7;      // file register address
  localparam int FILE_LSB = 0;
  localparam int BITN_MSB = 11;     // bit number
  localparam int BITN_LSB = 9;
  localparam int LIT_MSB = 7;       // literal byte
  localparam int LIT_LSB = 0;
  localparam int PTR_MSB = 5;       // indirect pointer select
  localparam int PTR_LSB = 4;
  localparam int LITHI_MSB = 3;     // upper literal nibble of pointer load
  localparam int LITHI_LSB = 0;
  localparam int FAST_CALL_BIT = 8; // fast mode in a call
  localparam int FAST_RET_BIT = 0;  // fast mode in a return
  localparam int TBL_MSB = 1;       // table pointer mode
  localparam int TBL_LSB = 0;
  localparam int WIDE_MSB = 11;     // 12-bit field of a second word
  localparam int WIDE_LSB = 0;
  localparam int BRA_MSB = 10;      // long relative offset
  localparam int SBR_MSB = 7;       // short relative offset

  localparam logic [3:0] SECOND_TAG = 4'hf;           // top nibble of every second word
  localparam logic [15:0] WORD_NOP = 16'h0000;        // plain no_operation word

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    CLS_NOP = 3'h0,
    CLS_BYTE = 3'h1,
    CLS_BIT = 3'h2,
    CLS_LIT = 3'h3,
    CLS_CTRL = 3'h4
  } ifd_class_type;

  typedef enum logic [0:0] {
    ST_SINGLE = 1'h0,
    ST_SECOND = 1'h1
  } ifd_state_type;

  typedef struct packed {
    ifd_class_type cls;     // instruction category
    logic [7:0] opcode;     // opcode byte of first word
    logic two_word;         // instruction spans two words
    logic [11:0] file_addr; // file register / source address
    logic [11:0] dst_addr;  // destination address of a two-word move
    logic dest_file;        // 1: result to file register, 0: to accumulator
    logic use_bank;         // 1: bank_select_reg picks the bank
    logic [2:0] bit_num;    // bit affected
    logic [19:0] literal;   // literal value
    logic [1:0] ptr_sel;    // indirect_pointer_reg to load
    logic [19:0] prog_addr; // program address or relative offset
    logic fast;             // shadow register save/restore
    logic [1:0] tbl_mode;   // table pointer mode
    logic pc_change;        // always changes the program counter
    logic cond;             // conditional: extra cycle when true
    logic discard;          // word dropped by a flush cycle
    logic [1:0] cycles;     // base instruction cycles
  } ifd_dec_type;

endpackage : ifd_pkg

//--- design/ifd_quarter_seq.sv
`timescale 1ns/1ps

// ****************************************
// oscillator quarter counter
// ****************************************
module ifd_quarter_seq
  import ifd_pkg::*;
(
  input wire logic clock,      // oscillator clock
  input wire logic rst,        // async reset, active high
  output logic [1:0] phase_ff  // current quarter of the cycle
);

  // four quarters then wrap
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      phase_ff <= QTR_RESET;
    end
    else if (phase_ff == QTR_LAST)
    begin
      phase_ff <= QTR_RESET;
    end
    else
    begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

endmodule : ifd_quarter_seq

//--- tb/ifd_prog_mem.sv
`timescale 1ns/1ps

// ****************************************
// program memory model
// ****************************************
module ifd_prog_mem
  import ifd_pkg::*;
(
  input wire logic clock,              // oscillator clock
  input wire logic rst,                // async reset, active high
  input wire logic fetch_ff,           // fetch pulse from decoder
  input wire logic [1:0] phase_ff,     // quarter of the cycle
  input wire logic slow,               // 1: word valid only in quarter 3
  output logic [15:0] instr_word       // word toward decoder
);
  logic [15:0] prog [0:15]; // program image, written by the bench
  logic [3:0] addr_ff;

  // word address steps once per fetch pulse
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      addr_ff <= 4'h0;
    end
    else if (fetch_ff)
    begin
      addr_ff <= addr_ff + 4'h1;
    end
  end

  // outside its valid window the bus shows the inverted word
  assign instr_word = (phase_ff == 2'h3 || (!slow && phase_ff != 2'h0)) ?
                      prog[addr_ff] : ~prog[addr_ff];
endmodule : ifd_prog_mem

//--- tb/tb_ifd_decode.sv
`timescale 1ns/1ps

module tb_ifd_decode
  import ifd_pkg::*;
();
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cond_true = 1'b0;
  logic slow = 1'b0;
  logic [15:0] instr_word;
  logic [1:0] phase_ff;
  logic fetch_ff;
  logic issue_ff;
  ifd_dec_type dec_ff;
  logic wr_accum_ff;
  ifd_dec_type got [0:15];
  logic wr_got [0:15];
  logic cond_vec [0:15];
  int err_count = 0;
  int total_checks = 0;

  // 250 MHz oscillator
  always #2 clock = ~clock;

  ifd_decode ifd_decode_inst (.clock(clock), .rst(rst), .instr_word(instr_word),
    .cond_true(cond_true), .phase_ff(phase_ff), .fetch_ff(fetch_ff),
    .issue_ff(issue_ff), .dec_ff(dec_ff), .wr_accum_ff(wr_accum_ff));

  ifd_prog_mem ifd_prog_mem_inst (.clock(clock), .rst(rst), .fetch_ff(fetch_ff),
    .phase_ff(phase_ff), .slow(slow), .instr_word(instr_word));

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk_val(input logic [19:0] g, input logic [19:0] e, input string m);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_val

  task automatic chk_cls(input ifd_class_type g, input ifd_class_type e, input string m);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s class %0d exp %0d", $time, m, g, e);
    end
  endtask : chk_cls

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // program load and run
  // ****************************************
  // first word of the program sits in the most significant of the n low slots of img
  task automatic load(input logic [255:0] img, input int n);
    for (int i = 0; i < 16; i++)
    begin
      ifd_prog_mem_inst.prog[i] = (i < n) ? img[16*(n-1-i) +: 16] : WORD_NOP;
      cond_vec[i] = 1'b0;
    end
  endtask : load

  // reset, then capture n issued decodes
  task automatic run_prog(input int n);
    int gap;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_val(20'({phase_ff, fetch_ff, issue_ff, wr_accum_ff}), 20'h0, "reset outs");
    chk_val(20'(|dec_ff), 20'h0, "reset dec");
    rst = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      #1;
      gap = 1;
      while (issue_ff !== 1'b1 && gap < 8)
      begin
        @(posedge clock);
        #1;
        gap++;
      end
      if (issue_ff !== 1'b1)
      begin
        err_count++;
        $display("MISMATCH t=%0t no issue pulse", $time);
        report_and_stop();
      end
      chk_val(20'(gap), 20'h4, "issue spacing");
      chk_val(20'({phase_ff, fetch_ff}), 20'h1, "phase at issue");
      got[i] = dec_ff;
      wr_got[i] = wr_accum_ff;
      cond_true = cond_vec[i];
    end
    cond_true = 1'b0;
  endtask : run_prog

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_byte;
    load(256'({16'h2655, 16'h25a7}), 2);
    run_prog(2);
    chk_cls(got[0].cls, CLS_BYTE, "byte cls");
    chk_val(20'(got[0].opcode), 20'h26, "opcode");
    chk_val(20'(got[0].file_addr[7:0]), 20'h55, "byte f");
    chk_val(20'({got[0].dest_file, wr_got[0]}), 20'h2, "dest 1");
    chk_val(20'({got[1].dest_file, wr_got[1]}), 20'h1, "dest 0");
    chk_val(20'({got[0].use_bank, got[1].use_bank}), 20'h1, "bank sel");
    chk_val(20'({got[1].two_word, got[1].cycles}), 20'h1, "single len");
  endtask : t_byte

  task automatic t_bit_lit;
    load(256'({16'h8b42, 16'h0e9c}), 2);
    run_prog(2);
    chk_cls(got[0].cls, CLS_BIT, "bit cls");
    chk_val(20'({got[0].bit_num, got[0].use_bank}), 20'hb, "bit num");
    chk_val(20'(got[0].file_addr[7:0]), 20'h42, "bit f");
    chk_cls(got[1].cls, CLS_LIT, "lit cls");
    chk_val(20'(got[1].literal[7:0]), 20'h9c, "literal");
  endtask : t_bit_lit

  task automatic t_two_word;
    load(256'({16'hc123, 16'hf456, 16'hee13, 16'hf0c5, 16'hed34, 16'hfabc,
               16'hef56, 16'hf789, 16'hf123, 16'h0e11}), 10);
    run_prog(10);
    for (int i = 0; i < 8; i += 2)
    begin
      chk_val(20'({got[i].two_word, got[i].cycles}), 20'h6, "two word");
    end
    chk_val(20'(got[1].dst_addr), 20'h456, "move dst");
    chk_val(20'(got[2].ptr_sel), 20'h1, "ptr sel");
    chk_val(20'(got[3].literal[7:0]), 20'hc5, "ptr lit");
    chk_val(20'({got[4].cls, got[4].fast}), 20'h9, "call fast");
    chk_val(20'(got[4].prog_addr[7:0]), 20'h34, "call low");
    chk_val(20'(got[5].prog_addr[19:8]), 20'habc, "call addr");
    chk_val(20'(got[7].prog_addr[19:8]), 20'h789, "goto addr");
    chk_val(20'({got[8].cls, got[8].discard}), 20'h0, "lone second");
    chk_val(20'({got[9].literal[7:0], got[9].discard}), 20'h22, "no flush");
  endtask : t_two_word

  task automatic t_flush;
    load(256'({16'h0013, 16'h0e22, 16'h0e33, 16'hb5aa, 16'h0e44, 16'hb5aa,
               16'h0e55, 16'h000a, 16'h0012}), 9);
    cond_vec[3] = 1'b1;
    run_prog(9);
    chk_cls(got[0].cls, CLS_CTRL, "ret cls");
    chk_val(20'({got[0].fast, got[0].pc_change}), 20'h3, "ret fast");
    chk_val(20'({got[1].cls, got[1].discard}), 20'h1, "pc flush");
    chk_val(20'({got[2].literal[7:0], got[2].discard}), 20'h66, "after flush");
    chk_val(20'({got[3].cond, got[3].bit_num}), 20'ha, "skip test");
    chk_val(20'({got[4].cls, got[4].discard}), 20'h1, "true flush");
    chk_val(20'({got[6].literal[7:0], got[6].discard}), 20'haa, "false keep");
    chk_val(20'({got[7].cls, got[7].tbl_mode}), 20'h12, "table mode");
    chk_val(20'(got[8].fast), 20'h0, "ret plain");
  endtask : t_flush

  // relative branches, bank literal, byte skip and bit op
  task automatic t_branch;
    load(256'({16'hd7fe, 16'h0e01, 16'he2f0, 16'h0e02, 16'h0105, 16'h6210, 16'h7310}), 7);
    cond_vec[2] = 1'b1;
    run_prog(7);
    chk_val(20'({got[0].cls, got[0].pc_change, got[0].cond}), 20'h12, "bra kind");
    chk_val(got[0].prog_addr, 20'hffffe, "bra offset");
    chk_val(20'({got[1].cls, got[1].discard}), 20'h1, "bra flush");
    chk_val(20'({got[2].cls, got[2].cond}), 20'h9, "cbr kind");
    chk_val(got[2].prog_addr, 20'hffff0, "cbr offset");
    chk_val(20'({got[3].cls, got[3].discard}), 20'h1, "cbr flush");
    chk_val(20'({got[4].cls, got[4].literal[7:0], got[4].discard}), 20'h60a, "bank lit");
    chk_val(20'({got[5].cls, got[5].cond, wr_got[5]}), 20'h6, "byte skip");
    chk_val(20'({got[6].cls, got[6].cond, got[6].discard}), 20'h8, "skip false");
  endtask : t_branch

  task automatic t_slow;
    slow = 1'b1;
    load(256'({16'hc0ab, 16'hf321, 16'h25a7}), 3);
    run_prog(3);
    chk_val(20'(got[0].file_addr), 20'h0ab, "slow src");
    chk_val(20'(got[1].dst_addr), 20'h321, "slow dst");
    chk_val(20'({got[2].cls, wr_got[2]}), 20'h3, "slow byte");
    slow = 1'b0;
  endtask : t_slow

  // main sequence
  initial
  begin
    load(256'h0, 0);
    t_byte();
    t_bit_lit();
    t_two_word();
    t_flush();
    t_branch();
    t_slow();
    report_and_stop();
  end
endmodule : tb_ifd_decode
